// ### hdl/swb_core.sv
/*
 * Program status word, bank selector, bank register storage, flag
 * update, jump condition decode and HL address generation of the core.
 * Assumes the instruction decoder drives the request ports on core_clk,
 * the stack logic stores the pushed word and supplies it on return.
 */
// Notes on behaviour
// (RQ1) the 4-bit bank selector picks which of sixteen banks is current
// (RQ2) reset clears the bank selector, making bank 0 current
// (RQ3) status word at data address 003f, bank low nibble, flags high
// (RQ4) memory write to status word sets bank only, and jump flag to one
// (RQ5) interrupt pushes status word; interrupt return restores it whole
// (RQ6) reset sets jump flag, leaves zero, carry and half carry alone
// (RQ7) jump conditions test jump, zero, carry, or carry-or-zero flags
// (RQ8) zero flag set when 8-bit or 16-bit result is zero
// (RQ9) bit set/clear/complement: zero flag is inverse of old bit
// (RQ10) multiply zero on upper product byte, divide zero on remainder
// (RQ11) carry flag is carry out of or borrow into msb
// (RQ12) divide sets carry on zero divisor or quotient of 100 or more
// (RQ13) shifts and rotates through carry load carry with bit shifted out
// (RQ14) 8-bit add/subtract/compare set half carry from bit 3 to 4
// (RQ15) half carry is undefined after 16-bit arithmetic
// (RQ16) arithmetic, increment, compare, test load jump flag with outcome
// (RQ17) load, exchange, swap, rotate-nibble and jump set jump flag
// (RQ18) HL addressing: displacement, plus C, post-increment, pre-decrement
// (RQ19) 16-by-8 divide: WA over C, quotient to A, remainder to W
// (RQ20) sixteen banks of eight registers at data 0040 to 00bf
// (RQ21) interrupt pushes status word first, then pc high, pc low
// (RQ22) flag bits: jump 7, zero 6, carry 5, half carry 4
`include "swb_defines.svh"
module swb_core
	import swb_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [15:0] mem_addr,
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata,
	output logic mem_hit,
	input wire logic [2:0] reg_rd_a_idx,
	output logic [7:0] reg_rd_a_data,
	input wire logic [2:0] reg_rd_b_idx,
	output logic [7:0] reg_rd_b_data,
	input wire logic reg_wr,
	input wire logic [2:0] reg_wr_idx,
	input wire logic [7:0] reg_wr_data,
	input wire logic alu_valid,
	input swb_pkg::swb_alu_req_s alu_req,
	output logic [15:0] alu_result,
	input wire logic ld_bank_valid,
	input wire logic [3:0] ld_bank_value,
	input wire logic int_accept,
	output logic [7:0] psw_push_data,
	input wire logic int_return,
	input wire logic [7:0] psw_pop_data,
	input swb_pkg::swb_cc_e jump_cc,
	output logic jump_taken,
	input wire logic am_valid,
	input swb_pkg::swb_am_e am_mode,
	input wire logic [15:0] am_hl,
	input wire logic [7:0] am_disp,
	input wire logic [7:0] am_creg,
	output logic [15:0] am_ea,
	output logic [15:0] am_hl_new,
	output logic am_done,
	output logic [7:0] program_status_word,
	output logic [3:0] bank_selector
);
	swb_psw_s psw_reg, psw_next;
	swb_alu_rsp_s alu_rsp;
	logic [7:0] push_reg, push_next, rdata_reg, rdata_next;
	logic rd_bank_reg, rd_bank_next, hit_reg, hit_next;
	logic [15:0] res_reg, res_next;
	logic [15:0] ea_reg, ea_next, hl_reg, hl_next;
	logic done_reg, done_next;
	logic psw_hit, bank_hit;
	logic [15:0] bank_off;
	logic [6:0] ram_waddr;
	logic [7:0] ram_wdata, ram_a_data;
	logic ram_wr;

	// ------------------------------------------------------------------
	// address decode and bank storage
	// ------------------------------------------------------------------
	assign psw_hit = mem_addr == `SWB_PSW_ADDR; // RQ3
	assign bank_hit = mem_addr >= `SWB_BANK_LO && mem_addr <= `SWB_BANK_HI; // RQ20
	assign bank_off = mem_addr - `SWB_BANK_LO;
	assign ram_wr = reg_wr || (mem_wr && bank_hit);
	// register port writes win a collision with a memory write
	assign ram_waddr = reg_wr ? {psw_reg.bank, reg_wr_idx} : bank_off[6:0]; // RQ1
	assign ram_wdata = reg_wr ? reg_wr_data : mem_wdata;

	swb_bank_ram #(
		.DW(8),
		.AW(7)
	) u_ram (
		.core_clk(core_clk),
		.wr(ram_wr),
		.waddr(ram_waddr),
		.wdata(ram_wdata),
		.a_addr(bank_off[6:0]),
		.a_data(ram_a_data),
		.b_addr({psw_reg.bank, reg_rd_a_idx}), // RQ1
		.b_data(reg_rd_a_data),
		.c_addr({psw_reg.bank, reg_rd_b_idx}),
		.c_data(reg_rd_b_data)
	);

	swb_flag_alu u_alu (
		.req(alu_req),
		.flags_in(psw_reg.flags),
		.rsp(alu_rsp)
	);

	// ------------------------------------------------------------------
	// status word update
	// ------------------------------------------------------------------
	always_comb begin
		psw_next = psw_reg;
		push_next = push_reg;
		res_next = res_reg;
		if (alu_valid) begin
			psw_next.flags = alu_rsp.flags;
			res_next = alu_rsp.res;
		end
		if (ld_bank_valid) begin
			psw_next.bank = ld_bank_value; // RQ1
			psw_next.flags.jf = 1'b1; // RQ17
		end
		if (mem_wr && psw_hit) begin
			psw_next.bank = mem_wdata[3:0]; // RQ4
			psw_next.flags.jf = 1'b1; // RQ4
		end
		if (int_return) begin
			psw_next = swb_psw_s'(psw_pop_data); // RQ5
		end
		if (int_accept) begin
			push_next = psw_reg; // RQ5 RQ21
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			psw_reg.bank <= `SWB_RBS_RST; // RQ2
			psw_reg.flags.jf <= `SWB_JF_RST; // RQ6
			push_reg <= `SWB_ZERO8;
			res_reg <= `SWB_ZERO16;
		end else begin
			psw_reg <= psw_next;
			push_reg <= push_next;
			res_reg <= res_next;
		end
	end

	// ------------------------------------------------------------------
	// memory read answer
	// ------------------------------------------------------------------
	always_comb begin
		rdata_next = `SWB_RD_NONE;
		rd_bank_next = 1'b0;
		hit_next = 1'b0;
		if (mem_rd) begin
			hit_next = psw_hit || bank_hit;
			rd_bank_next = bank_hit;
			if (psw_hit) begin
				rdata_next = psw_reg; // RQ3 RQ22
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rdata_reg <= `SWB_RD_NONE;
			rd_bank_reg <= 1'b0;
			hit_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			rd_bank_reg <= rd_bank_next;
			hit_reg <= hit_next;
		end
	end

	assign mem_rdata = rd_bank_reg ? ram_a_data : rdata_reg; // RQ20
	assign mem_hit = hit_reg;

	// ------------------------------------------------------------------
	// jump condition decode
	// ------------------------------------------------------------------
	always_comb begin
		unique case (jump_cc)
			SWB_CC_T: jump_taken = psw_reg.flags.jf; // RQ7
			SWB_CC_F: jump_taken = !psw_reg.flags.jf; // RQ7
			SWB_CC_Z, SWB_CC_EQ: jump_taken = psw_reg.flags.zf; // RQ7
			SWB_CC_NZ, SWB_CC_NE: jump_taken = !psw_reg.flags.zf; // RQ7
			SWB_CC_CS, SWB_CC_LT: jump_taken = psw_reg.flags.cf; // RQ7
			SWB_CC_CC, SWB_CC_GE: jump_taken = !psw_reg.flags.cf; // RQ7
			SWB_CC_LE: jump_taken = psw_reg.flags.cf || psw_reg.flags.zf; // RQ7
			SWB_CC_GT: jump_taken = !(psw_reg.flags.cf || psw_reg.flags.zf); // RQ7
			default: jump_taken = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// HL address generation
	// ------------------------------------------------------------------
	always_comb begin
		ea_next = ea_reg;
		hl_next = hl_reg;
		done_next = am_valid;
		if (am_valid) begin
			hl_next = am_hl;
			ea_next = am_hl;
			unique case (am_mode)
				SWB_AM_HL: ea_next = am_hl;
				SWB_AM_HL_DISP: ea_next = am_hl + {{8{am_disp[7]}}, am_disp}; // RQ18
				SWB_AM_HL_C: ea_next = am_hl + {8'h00, am_creg}; // RQ18
				SWB_AM_HL_POSTINC: hl_next = am_hl + `SWB_HL_STEP; // RQ18
				SWB_AM_HL_PREDEC: begin
					hl_next = am_hl - `SWB_HL_STEP; // RQ18
					ea_next = am_hl - `SWB_HL_STEP;
				end
				default: ea_next = am_hl;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ea_reg <= `SWB_ZERO16;
			hl_reg <= `SWB_ZERO16;
			done_reg <= 1'b0;
		end else begin
			ea_reg <= ea_next;
			hl_reg <= hl_next;
			done_reg <= done_next;
		end
	end

	assign am_ea = ea_reg;
	assign am_hl_new = hl_reg;
	assign am_done = done_reg;
	assign alu_result = res_reg;
	assign psw_push_data = push_reg;
	assign program_status_word = psw_reg;
	assign bank_selector = psw_reg.bank;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	chk_reset_bank: assert property ($rose(resetn) |-> bank_selector == `SWB_RBS_RST) // RQ2
		else $error("bank selector not zero after reset");
	chk_reset_jf: assert property ($rose(resetn) |-> program_status_word[7]) // RQ6
		else $error("jump flag not set after reset");
	chk_psw_wr_bank: assert property (mem_wr && psw_hit && !int_return
		|=> bank_selector == $past(mem_wdata[3:0]) && program_status_word[7]) // RQ4
		else $error("status word write did not load bank and jump flag");
	chk_psw_wr_flags: assert property (mem_wr && psw_hit && !int_return
		&& !alu_valid |=> program_status_word[6:4]
		== $past(program_status_word[6:4])) // RQ4
		else $error("status word write changed flags");
	chk_jump_le: assert property (jump_cc == SWB_CC_LE
		|-> jump_taken == (program_status_word[5] || program_status_word[6])) // RQ7
		else $error("less-equal condition wrong");
	chk_div_zero: assert property (alu_valid && alu_req.op == SWB_OP_DIV
		&& alu_req.opb[7:0] == `SWB_ZERO8 && !int_return
		|=> program_status_word[5]) // RQ12
		else $error("divide by zero did not set carry");
	chk_push_word: assert property (int_accept
		|=> psw_push_data == $past(program_status_word)) // RQ5
		else $error("pushed word is not the status word");
	chk_pop_word: assert property (int_return
		|=> program_status_word == $past(psw_pop_data)) // RQ5
		else $error("return did not restore status word");
	chk_am_predec: assert property (am_valid && am_mode == SWB_AM_HL_PREDEC
		|=> am_done && am_ea == am_hl_new
		&& am_hl_new == $past(am_hl) - `SWB_HL_STEP) // RQ18
		else $error("pre-decrement address wrong");
	chk_load_jf: assert property (alu_valid && alu_req.op == SWB_OP_LOAD
		&& !int_return |=> program_status_word[7]) // RQ17
		else $error("load did not set jump flag");
	chk_psw_read: assert property (mem_rd && psw_hit && !mem_wr && !alu_valid
		&& !int_return && !ld_bank_valid
		|=> mem_hit && mem_rdata == program_status_word) // RQ3
		else $error("status word read mismatch");

	cov_int_cycle: cover property (int_accept ##[1:20] int_return);
	cov_div_err: cover property (alu_valid && alu_req.op == SWB_OP_DIV
		&& alu_req.opb[7:0] == `SWB_ZERO8);
	cov_jump_gt: cover property (jump_cc == SWB_CC_GT && jump_taken);
	cov_bank_rd: cover property (mem_rd && bank_hit ##1 mem_hit);
endmodule

// ### include/swb_defines.svh
/*
 * Constants of the status word and register bank block: data addresses,
 * reset values and fixed values.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef SWB_DEFINES_SVH
`define SWB_DEFINES_SVH

// ----------------------------------------------------------------------
// data memory map
// ----------------------------------------------------------------------
`define SWB_PSW_ADDR 16'h003f
`define SWB_BANK_LO 16'h0040
`define SWB_BANK_HI 16'h00bf

// ----------------------------------------------------------------------
// reset values and fixed values
// ----------------------------------------------------------------------
`define SWB_RBS_RST 4'h0
`define SWB_JF_RST 1'b1
`define SWB_RD_NONE 8'h00
`define SWB_ZERO8 8'h00
`define SWB_ZERO16 16'h0000
`define SWB_ONE8 8'h01
`define SWB_HL_STEP 16'h0001
`define SWB_DIV_SAFE 8'h01

`endif

// ### include/swb_pkg.sv
/*
 * Types of the status word and register bank block.
 * Assumes swb_defines.svh is on the include path.
 */
package swb_pkg;
	`include "swb_defines.svh"

	// ------------------------------------------------------------------
	// status word layout: flags in the upper nibble, bank in the lower
	// ------------------------------------------------------------------
	typedef struct packed {
		logic jf;
		logic zf;
		logic cf;
		logic hf;
	} swb_flags_s;

	typedef struct packed {
		swb_flags_s flags;
		logic [3:0] bank;
	} swb_psw_s;

	// ------------------------------------------------------------------
	// operations, jump conditions and addressing modes
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		SWB_OP_NONE, SWB_OP_ADD, SWB_OP_ADDC, SWB_OP_SUB, SWB_OP_SUBB,
		SWB_OP_CMP, SWB_OP_ADD16, SWB_OP_SUB16, SWB_OP_INC, SWB_OP_AND,
		SWB_OP_MUL, SWB_OP_DIV, SWB_OP_SHIFT_LEFT_THROUGH_CARRY, SWB_OP_SHRC, SWB_OP_ROLC,
		SWB_OP_ROTATE_RIGHT_THROUGH_CARRY, SWB_OP_TEST, SWB_OP_SETB, SWB_OP_CLRB, SWB_OP_CPLB,
		SWB_OP_LOAD, SWB_OP_XFER
	} swb_op_e;

	typedef enum logic [3:0] {
		SWB_CC_T, SWB_CC_F, SWB_CC_Z, SWB_CC_NZ, SWB_CC_CS, SWB_CC_CC,
		SWB_CC_EQ, SWB_CC_NE, SWB_CC_LT, SWB_CC_GE, SWB_CC_LE, SWB_CC_GT
	} swb_cc_e;

	typedef enum logic [2:0] {
		SWB_AM_HL, SWB_AM_HL_DISP, SWB_AM_HL_C, SWB_AM_HL_POSTINC,
		SWB_AM_HL_PREDEC
	} swb_am_e;

	typedef struct packed {
		swb_op_e op;
		logic [15:0] opa;
		logic [15:0] opb;
	} swb_alu_req_s;

	typedef struct packed {
		logic [15:0] res;
		swb_flags_s flags;
	} swb_alu_rsp_s;
endpackage

// ### hdl/swb_bank_ram.sv
/*
 * Register bank storage: one write port, three read ports, each read
 * data out of a register one cycle after its address.
 * Assumes a single clock; write and read of one entry return old data.
 */
module swb_bank_ram #(
	parameter int DW = 8,
	parameter int AW = 7
) (
	input wire logic core_clk,
	input wire logic wr,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] a_addr,
	output logic [DW-1:0] a_data,
	input wire logic [AW-1:0] b_addr,
	output logic [DW-1:0] b_data,
	input wire logic [AW-1:0] c_addr,
	output logic [DW-1:0] c_data
);
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge core_clk) begin
		if (wr) begin
			mem[waddr] <= wdata;
		end
		a_data <= mem[a_addr];
		b_data <= mem[b_addr];
		c_data <= mem[c_addr];
	end
endmodule

// ### hdl/swb_flag_alu.sv
/*
 * Result and flag computation for one operation; purely combinational.
 * Assumes the caller registers result and flags when the request is valid.
 */
`include "swb_defines.svh"
module swb_flag_alu
	import swb_pkg::*;
(
	input swb_pkg::swb_alu_req_s req,
	input swb_pkg::swb_flags_s flags_in,
	output swb_pkg::swb_alu_rsp_s rsp
);
	logic [7:0] a8, b8, mask, dsor;
	logic cin;
	logic [8:0] add9, sub9;
	logic [4:0] hadd, hsub;
	logic [16:0] add17, sub17;
	logic [15:0] prod, quot, rem;

	always_comb begin
		a8 = req.opa[7:0];
		b8 = req.opb[7:0];
		cin = flags_in.cf;
		mask = `SWB_ONE8 << req.opb[2:0];
		dsor = (b8 == `SWB_ZERO8) ? `SWB_DIV_SAFE : b8;
		add9 = {1'b0, a8} + {1'b0, b8} + {8'h00, req.op == SWB_OP_ADDC && cin};
		sub9 = {1'b0, a8} - {1'b0, b8} - {8'h00, req.op == SWB_OP_SUBB && cin};
		hadd = {1'b0, a8[3:0]} + {1'b0, b8[3:0]}
			+ {4'h0, req.op == SWB_OP_ADDC && cin};
		hsub = {1'b0, a8[3:0]} - {1'b0, b8[3:0]}
			- {4'h0, req.op == SWB_OP_SUBB && cin};
		add17 = {1'b0, req.opa} + {1'b0, req.opb};
		sub17 = {1'b0, req.opa} - {1'b0, req.opb};
		prod = a8 * b8;
		quot = req.opa / {8'h00, dsor};
		rem = req.opa % {8'h00, dsor};
		rsp.res = req.opa;
		rsp.flags = flags_in;
		unique case (req.op)
			SWB_OP_ADD, SWB_OP_ADDC: begin
				rsp.res = {8'h00, add9[7:0]};
				rsp.flags.cf = add9[8]; // RQ11
				rsp.flags.hf = hadd[4]; // RQ14
			end
			SWB_OP_SUB, SWB_OP_SUBB, SWB_OP_CMP: begin
				if (req.op != SWB_OP_CMP) begin
					rsp.res = {8'h00, sub9[7:0]};
				end
				rsp.flags.cf = sub9[8]; // RQ11
				rsp.flags.hf = hsub[4]; // RQ14
			end
			SWB_OP_ADD16: begin
				rsp.res = add17[15:0];
				rsp.flags.cf = add17[16]; // RQ11
			end
			SWB_OP_SUB16: begin
				rsp.res = sub17[15:0];
				rsp.flags.cf = sub17[16]; // RQ11
			end
			SWB_OP_INC: rsp.res = {8'h00, a8 + `SWB_ONE8};
			SWB_OP_AND: rsp.res = {8'h00, a8 & b8};
			SWB_OP_MUL: rsp.res = prod;
			SWB_OP_DIV: begin
				// quotient to the low byte, remainder to the high byte
				if (b8 != `SWB_ZERO8) begin
					rsp.res = {rem[7:0], quot[7:0]}; // RQ19
				end
				rsp.flags.cf = (b8 == `SWB_ZERO8) || (quot[15:8] != `SWB_ZERO8); // RQ12
			end
			SWB_OP_SHIFT_LEFT_THROUGH_CARRY: begin
				rsp.res = {8'h00, a8[6:0], 1'b0};
				rsp.flags.cf = a8[7]; // RQ13
			end
			SWB_OP_ROLC: begin
				rsp.res = {8'h00, a8[6:0], cin};
				rsp.flags.cf = a8[7]; // RQ13
			end
			SWB_OP_SHRC: begin
				rsp.res = {8'h00, 1'b0, a8[7:1]};
				rsp.flags.cf = a8[0]; // RQ13
			end
			SWB_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
				rsp.res = {8'h00, cin, a8[7:1]};
				rsp.flags.cf = a8[0]; // RQ13
			end
			SWB_OP_SETB: rsp.res = {8'h00, a8 | mask};
			SWB_OP_CLRB: rsp.res = {8'h00, a8 & ~mask};
			SWB_OP_CPLB: rsp.res = {8'h00, a8 ^ mask};
			SWB_OP_LOAD: rsp.res = {8'h00, b8};
			default: rsp.res = req.opa;
		endcase
		unique case (req.op)
			SWB_OP_ADD16, SWB_OP_SUB16: begin
				// half carry keeps its old value, which is as good as any
				rsp.flags.zf = rsp.res == `SWB_ZERO16; // RQ8 RQ15
			end
			SWB_OP_MUL: rsp.flags.zf = prod[15:8] == `SWB_ZERO8; // RQ10
			SWB_OP_DIV: rsp.flags.zf = rem[7:0] == `SWB_ZERO8; // RQ10
			SWB_OP_TEST, SWB_OP_SETB, SWB_OP_CLRB, SWB_OP_CPLB: begin
				rsp.flags.zf = (a8 & mask) == `SWB_ZERO8; // RQ9
			end
			SWB_OP_CMP: rsp.flags.zf = sub9[7:0] == `SWB_ZERO8; // RQ8
			SWB_OP_NONE, SWB_OP_XFER: rsp.flags.zf = flags_in.zf;
			default: rsp.flags.zf = rsp.res[7:0] == `SWB_ZERO8; // RQ8
		endcase
		unique case (req.op)
			SWB_OP_NONE: rsp.flags.jf = flags_in.jf;
			SWB_OP_LOAD, SWB_OP_XFER: rsp.flags.jf = 1'b1; // RQ17
			SWB_OP_ADD, SWB_OP_ADDC, SWB_OP_SUB, SWB_OP_SUBB, SWB_OP_ADD16,
			SWB_OP_SUB16, SWB_OP_DIV, SWB_OP_SHIFT_LEFT_THROUGH_CARRY, SWB_OP_SHRC, SWB_OP_ROLC,
			SWB_OP_ROTATE_RIGHT_THROUGH_CARRY: rsp.flags.jf = rsp.flags.cf; // RQ16
			default: rsp.flags.jf = rsp.flags.zf; // RQ16
		endcase
	end
endmodule

// ### dv/tb_status_word_bank_select_flags.sv
/*
 * Self-checking bench of swb_core: flags, status word, banks, jumps,
 * interrupt save/restore and HL addressing.
 * Assumes swb_pkg is compiled first; the bench drives every port itself.
 */
module tb_status_word_bank_select_flags
	import swb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------------
	// signals and scoreboard
	// ------------------------------------------------------------------
	typedef struct {
		int cyc;
		int sel;
		logic [15:0] exp;
		logic [15:0] msk;
		string nm;
	} swb_note_s;
	logic core_clk, resetn, mem_wr, mem_rd, mem_hit, reg_wr, alu_valid;
	logic ld_bank_valid, int_accept, int_return, jump_taken, am_valid;
	logic am_done;
	logic [15:0] mem_addr, alu_result, am_hl, am_ea, am_hl_new;
	logic [7:0] mem_wdata, mem_rdata, reg_rd_a_data, reg_rd_b_data;
	logic [7:0] reg_wr_data, psw_push_data, psw_pop_data, am_disp, am_creg;
	logic [7:0] program_status_word, p;
	logic [2:0] reg_rd_a_idx, reg_rd_b_idx, reg_wr_idx;
	logic [3:0] ld_bank_value, bank_selector;
	logic [8:0] s;
	swb_alu_req_s alu_req;
	swb_cc_e jump_cc;
	swb_am_e am_mode;
	swb_note_s expq[$];
	swb_note_s nt;
	int ncyc = 0;
	int n_fail = 0;
	int samples_checked = 0;
	int rv;
	swb_core uut (.core_clk(core_clk), .resetn(resetn),
		.mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_hit(mem_hit),
		.reg_rd_a_idx(reg_rd_a_idx), .reg_rd_a_data(reg_rd_a_data),
		.reg_rd_b_idx(reg_rd_b_idx), .reg_rd_b_data(reg_rd_b_data),
		.reg_wr(reg_wr), .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data),
		.alu_valid(alu_valid), .alu_req(alu_req), .alu_result(alu_result),
		.ld_bank_valid(ld_bank_valid), .ld_bank_value(ld_bank_value),
		.int_accept(int_accept), .psw_push_data(psw_push_data),
		.int_return(int_return), .psw_pop_data(psw_pop_data),
		.jump_cc(jump_cc), .jump_taken(jump_taken), .am_valid(am_valid),
		.am_mode(am_mode), .am_hl(am_hl), .am_disp(am_disp),
		.am_creg(am_creg), .am_ea(am_ea), .am_hl_new(am_hl_new),
		.am_done(am_done), .program_status_word(program_status_word),
		.bank_selector(bank_selector));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) ncyc <= ncyc + 1;
	function automatic logic [15:0] got(input int sel);
		case (sel)
			0: return {8'h00, program_status_word};
			1: return alu_result;
			2: return {8'h00, mem_rdata};
			3: return am_ea;
			4: return am_hl_new;
			5: return {15'h0000, jump_taken};
			6: return {8'h00, psw_push_data};
			7: return {15'h0000, mem_hit};
			8: return {8'h00, reg_rd_a_data};
			9: return {15'h0000, am_done};
			10: return {12'h000, bank_selector};
			default: return {8'h00, reg_rd_b_data};
		endcase
	endfunction
	// every note whose cycle has come is compared against the outputs, oldest first
	always @(negedge core_clk) begin
		while (expq.size() > 0 && expq[0].cyc <= ncyc) begin
			nt = expq.pop_front();
			samples_checked++;
			if ((got(nt.sel) & nt.msk) !== (nt.exp & nt.msk)) begin
				n_fail++;
				$display("mismatch %s expected %h seen %h", nt.nm,
					nt.exp & nt.msk, got(nt.sel) & nt.msk);
			end
		end
	end
	// ------------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------------
	task automatic note(input int sel, input logic [15:0] e, m,
		input string nm);
		expq.push_back('{ncyc + 1, sel, e, m, nm});
	endtask
	task automatic alu(input swb_op_e op, input logic [15:0] a, b, r, rm,
		input logic [3:0] f, fm);
		@(negedge core_clk);
		alu_valid = 1'b1;
		alu_req = '{op, a, b};
		note(1, r, rm, "alu_result");
		note(0, {8'h00, f, 4'h0}, {8'h00, fm, 4'h0}, "flags");
		@(negedge core_clk);
		alu_valid = 1'b0;
	endtask
	task automatic mem(input logic w, input logic [15:0] ad,
		input logic [7:0] d, input logic h, input logic [7:0] dm);
		@(negedge core_clk);
		mem_wr = w;
		mem_rd = !w;
		mem_addr = ad;
		mem_wdata = d;
		if (!w) begin
			note(2, {8'h00, d}, {8'h00, dm}, "mem_rdata");
			note(7, {15'h0000, h}, 16'h0001, "mem_hit");
		end
		@(negedge core_clk);
		mem_wr = 1'b0;
		mem_rd = 1'b0;
	endtask
	task automatic ldb(input logic [3:0] v);
		@(negedge core_clk);
		ld_bank_valid = 1'b1;
		ld_bank_value = v;
		@(negedge core_clk);
		ld_bank_valid = 1'b0;
	endtask
	task automatic regw(input logic [2:0] i, input logic [7:0] d);
		@(negedge core_clk);
		reg_wr = 1'b1;
		reg_wr_idx = i;
		reg_wr_data = d;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask
	task automatic regr(input logic [2:0] i, j, input logic [7:0] a, b);
		@(negedge core_clk);
		reg_rd_a_idx = i;
		reg_rd_b_idx = j;
		note(8, {8'h00, a}, 16'h00ff, "reg_rd_a_data");
		note(11, {8'h00, b}, 16'h00ff, "reg_rd_b_data");
		@(negedge core_clk);
	endtask
	task automatic irq(input logic acc, input logic [7:0] pop);
		@(negedge core_clk);
		int_accept = acc;
		int_return = !acc;
		psw_pop_data = pop;
		@(negedge core_clk);
		int_accept = 1'b0;
		int_return = 1'b0;
	endtask
	task automatic am(input swb_am_e md, input logic [15:0] hl,
		input logic [7:0] d, c, input logic [15:0] ea, hn);
		@(negedge core_clk);
		am_valid = 1'b1;
		am_mode = md;
		am_hl = hl;
		am_disp = d;
		am_creg = c;
		note(3, ea, 16'hffff, "am_ea");
		note(4, hn, 16'hffff, "am_hl_new");
		note(9, 16'h0001, 16'h0001, "am_done");
		@(negedge core_clk);
		am_valid = 1'b0;
	endtask
	function automatic logic jexp(input int cc, input logic [7:0] f);
		case (cc)
			0: return f[7];
			1: return !f[7];
			2, 6: return f[6];
			3, 7: return !f[6];
			4, 8: return f[5];
			5, 9: return !f[5];
			10: return f[5] | f[6];
			default: return !(f[5] | f[6]);
		endcase
	endfunction
	task automatic finish_test();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		n_fail++;
		$display("watchdog expired");
		finish_test();
	end
	// ------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------
	initial begin
		{mem_wr, mem_rd, reg_wr, alu_valid, ld_bank_valid} = 5'h00;
		{int_accept, int_return, am_valid} = 3'h0;
		{mem_addr, mem_wdata, reg_wr_idx, reg_wr_data} = 35'h000000000;
		{reg_rd_a_idx, reg_rd_b_idx, ld_bank_value} = 10'h000;
		{psw_pop_data, am_hl, am_disp, am_creg} = 40'h0000000000;
		alu_req = '0;
		jump_cc = SWB_CC_T;
		am_mode = SWB_AM_HL;
		rv = $urandom(32'hf32d);
		resetn = 1'b0;
		repeat (16) @(posedge core_clk);
		@(negedge core_clk);
		resetn = 1'b1;
		note(0, 16'h0080, 16'h008f, "reset psw");
		$display("test reset done");
		alu(SWB_OP_ADD, 16'h19, 16'h28, 16'h41, 16'hff, 4'h1, 4'hf);
		alu(SWB_OP_ADD, 16'h9a, 16'h66, 16'h0, 16'hff, 4'hf, 4'hf);
		alu(SWB_OP_ADDC, 16'h9a, 16'hd7, 16'h72, 16'hff, 4'hb, 4'hf);
		alu(SWB_OP_SUBB, 16'h9a, 16'hd7, 16'hc2, 16'hff, 4'ha, 4'hf);
		alu(SWB_OP_CMP, 16'h9a, 16'hd7, 16'h9a, 16'hff, 4'h2, 4'hf);
		alu(SWB_OP_AND, 16'h9a, 16'hd7, 16'h92, 16'hff, 4'h2, 4'he);
		alu(SWB_OP_LOAD, 16'h0, 16'hd7, 16'hd7, 16'hff, 4'ha, 4'he);
		alu(SWB_OP_INC, 16'h9a, 16'h0, 16'h9b, 16'hff, 4'h2, 4'he);
		alu(SWB_OP_ROLC, 16'h9a, 16'h0, 16'h35, 16'hff, 4'ha, 4'he);
		alu(SWB_OP_ROTATE_RIGHT_THROUGH_CARRY, 16'h9a, 16'h0, 16'hcd, 16'hff, 4'h0, 4'he);
		alu(SWB_OP_SETB, 16'h9a, 16'h5, 16'hba, 16'hff, 4'hc, 4'hc);
		alu(SWB_OP_CLRB, 16'h9a, 16'h1, 16'h98, 16'hff, 4'h0, 4'hc);
		alu(SWB_OP_CPLB, 16'h9a, 16'h0, 16'h9b, 16'hff, 4'hc, 4'hc);
		alu(SWB_OP_TEST, 16'h9a, 16'h3, 16'h9a, 16'hff, 4'h0, 4'hc);
		alu(SWB_OP_ADD16, 16'h219a, 16'hf508, 16'h16a2, 16'hffff, 4'ha, 4'he);
		alu(SWB_OP_SUB16, 16'h1234, 16'h1234, 16'h0, 16'hffff, 4'h4, 4'he);
		alu(SWB_OP_SUB16, 16'h0, 16'h1, 16'hffff, 16'hffff, 4'ha, 4'he);
		alu(SWB_OP_MUL, 16'h21, 16'h9a, 16'h13da, 16'hffff, 4'h0, 4'hc);
		alu(SWB_OP_MUL, 16'h1, 16'h5, 16'h5, 16'hffff, 4'hc, 4'hc);
		alu(SWB_OP_DIV, 16'h0405, 16'h4, 16'h0, 16'h0, 4'ha, 4'ha);
		alu(SWB_OP_DIV, 16'h00ff, 16'h10, 16'h0f0f, 16'hffff, 4'h0, 4'he);
		alu(SWB_OP_DIV, 16'h0040, 16'h8, 16'h8, 16'hffff, 4'h4, 4'he);
		alu(SWB_OP_DIV, 16'h1234, 16'h0, 16'h0, 16'h0, 4'ha, 4'ha);
		alu(SWB_OP_SHIFT_LEFT_THROUGH_CARRY, 16'h81, 16'h0, 16'h2, 16'hfe, 4'ha, 4'ha);
		alu(SWB_OP_SHRC, 16'h1, 16'h0, 16'h0, 16'h7f, 4'ha, 4'ha);
		alu(SWB_OP_SUB, 16'h10, 16'h1, 16'hf, 16'hff, 4'h1, 4'hf);
		alu(SWB_OP_SUB, 16'h0, 16'h1, 16'hff, 16'hff, 4'hb, 4'hf);
		alu(SWB_OP_XFER, 16'h0, 16'h0, 16'h0, 16'h0, 4'h8, 4'h8);
		for (int k = 0; k < 8; k++) begin
			p = 8'($urandom);
			s = 9'(p) + 9'($urandom % 256) ;
			alu(SWB_OP_ADD, {8'h00, p}, {7'h00, s - 9'(p)}, {7'h00, s}, 16'hff,
				{s[8], s[7:0] == 8'h00, s[8], p[3:0] + s[3:0] - p[3:0] < p[3:0]},
				4'he);
		end
		$display("test flags done");
		alu(SWB_OP_ADD, 16'h19, 16'h28, 16'h41, 16'hff, 4'h1, 4'hf);
		p = 8'($urandom);
		mem(1'b1, 16'h003f, p, 1'b0, 8'h00);
		note(0, {8'h00, 4'h9, p[3:0]}, 16'h00ff, "psw write");
		note(10, {12'h000, p[3:0]}, 16'h000f, "bank_selector");
		mem(1'b0, 16'h003f, {4'h9, p[3:0]}, 1'b1, 8'hff);
		mem(1'b1, 16'h003e, 8'h00, 1'b0, 8'h00);
		mem(1'b0, 16'h00c0, 8'h00, 1'b0, 8'hff);
		mem(1'b0, 16'h003f, {4'h9, p[3:0]}, 1'b1, 8'hff);
		ldb(4'h2);
		note(0, 16'h0082, 16'h008f, "bank load");
		regw(3'h3, 8'h5a);
		mem(1'b0, 16'h0053, 8'h5a, 1'b1, 8'hff);
		mem(1'b1, 16'h0068, 8'hc3, 1'b0, 8'h00);
		ldb(4'h5);
		regw(3'h7, 8'h3c);
		regr(3'h0, 3'h7, 8'hc3, 8'h3c);
		mem(1'b0, 16'h006f, 8'h3c, 1'b1, 8'hff);
		mem(1'b0, 16'h00bf, 8'h00, 1'b1, 8'h00);
		$display("test banks done");
		irq(1'b0, 8'h47);
		irq(1'b1, 8'h00);
		note(6, 16'h0047, 16'h00ff, "psw_push_data");
		ldb(4'h3);
		note(0, 16'h00c3, 16'h00ff, "bank load");
		irq(1'b0, 8'h47);
		note(0, 16'h0047, 16'h00ff, "psw restore");
		for (int k = 0; k < 4; k++) begin
			p = 8'($urandom);
			irq(1'b0, p);
			for (int c = 0; c < 12; c++) begin
				@(negedge core_clk);
				jump_cc = swb_cc_e'(c[3:0]);
				note(5, {15'h0000, jexp(c, p)}, 16'h0001, "jump_taken");
				@(negedge core_clk);
			end
		end
		$display("test jumps done");
		am(SWB_AM_HL, 16'h1234, 8'h00, 8'h00, 16'h1234, 16'h1234);
		am(SWB_AM_HL_DISP, 16'h1234, 8'h52, 8'h00, 16'h1286, 16'h1234);
		am(SWB_AM_HL_DISP, 16'h1234, 8'hf0, 8'h00, 16'h1224, 16'h1234);
		am(SWB_AM_HL_C, 16'h1234, 8'h00, 8'hff, 16'h1333, 16'h1234);
		am(SWB_AM_HL_POSTINC, 16'hffff, 8'h00, 8'h00, 16'hffff, 16'h0);
		am(SWB_AM_HL_PREDEC, 16'h0000, 8'h00, 8'h00, 16'hffff, 16'hffff);
		$display("test addressing done");
		irq(1'b0, 8'h7a);
		@(negedge core_clk);
		resetn = 1'b0;
		@(negedge core_clk);
		resetn = 1'b1;
		note(0, 16'h00f0, 16'h00ff, "second reset");
		repeat (4) @(negedge core_clk);
		$display("test second reset done");
		finish_test();
	end
endmodule
